// [hdl/lpg_sequencer.sv]
// protection qualification and adaptive dead-time gate sequencing
`timescale 1ns/1ps
`include "lpg_params.svh"
module lpg_sequencer #(
  parameter int AVG_HIGH_CYC = `LPG_AVG_HIGH_CYC,
  parameter int AVG_LOW_CYC = `LPG_AVG_LOW_CYC,
  parameter int MAX_DEAD_CYC = `LPG_MAX_DEAD_CYC,
  parameter int ONTIME_CYC = `LPG_ONTIME_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // comparators and control
  input wire lpg_pkg::lpg_sense_t sense,
  input wire logic rampEnable,
  input wire logic burstOff,
  input wire logic faultClear,
  // gate and analogue controls
  output logic topGateDrive,
  output logic bottomGateDrive,
  output logic avgMuxPass,
  output logic auxSampleStrobe,
  output logic rampPullDown,
  output logic rampDone,
  output logic driverLowPower,
  output logic startSourceOff,
  output logic bulkOverSelFall,
  output logic capacitiveFlag,
  // fault report
  output lpg_pkg::lpg_faults_t faults
);
  import lpg_pkg::*;

  // blanking length after each gate turns off, in clocks
  localparam int BLANK_CYC = `LPG_BLANK_CYC;
  // timer width, wide enough for the low average count
  localparam int TW = 20;

  // phase state and its next value
  lpg_phase_t phase_reg; // gate phase now
  lpg_phase_t phase_next; // gate phase for the next clock
  // timers
  logic [TW-1:0] phaseCnt_reg; // cycles in current phase
  logic [TW-1:0] highCnt_reg; // high-average persistence
  logic [TW-1:0] lowCnt_reg; // low-average persistence
  // peak overcurrent bookkeeping
  logic [3:0] startCnt_reg; // switching cycles since start
  logic [2:0] peakRun_reg; // consecutive peak events
  logic peakSeen_reg; // peak event in this positive half
  // sense history and enables
  logic dirPrev_reg; // direction one cycle ago
  logic running_reg; // switching allowed
  // gate drive flip-flops
  logic topGate_reg; // top gate drive
  logic botGate_reg; // bottom gate drive
  // protection state
  logic capFlag_reg; // capacitive region flag
  logic bulkOver_reg; // bulk overvoltage comparator, held
  logic sample_reg; // aux sample taken last clock
  lpg_faults_t faults_reg; // sticky and level faults

  // decoded conditions
  wire anyFault = |faults_reg; // any fault stops the gates
  // dead-time phases
  wire inDead = (phase_reg == LPG_DEAD_TO_BOT) || (phase_reg == LPG_DEAD_TO_TOP);
  // direction edges inside the blanking window are ignored
  wire blanked = inDead && (phaseCnt_reg < TW'(BLANK_CYC));
  wire dirFlip = (sense.currentDirection != dirPrev_reg) && !blanked;
  // dead time ends on slew, else a flip, else the timer
  wire deadEnd = sense.slewDone
    || dirFlip
    || (phaseCnt_reg >= TW'(MAX_DEAD_CYC - 1));
  // on time reached
  wire onEnd = phaseCnt_reg >= TW'(ONTIME_CYC - 1);
  wire topFall = (phase_reg == LPG_TOP_ON) && onEnd; // top gate about to drop
  wire botFall = (phase_reg == LPG_BOT_ON) && onEnd; // bottom gate about to drop
  // wrong polarity at a gate falling edge
  wire capEvent = (botFall && sense.currentDirection)
    || (topFall && !sense.currentDirection);
  // flag takes the verdict of each half cycle, held in between
  wire capFlagNext = (topFall || botFall) ? capEvent : capFlag_reg;
  // conditions that stop both gates
  wire stopNow = anyFault || !running_reg || burstOff || sense.railUv;
  // top gate is blocked by its own supply as well
  wire topAllowed = !stopNow && !sense.bootUv;
  // peak comparator only counts after the start-up cycles
  wire peakArmed = startCnt_reg == 4'(`LPG_PEAK_IGNORE);
  // qualified fault set, the average faults are sticky until faultClear
  wire highTrip = highCnt_reg >= TW'(AVG_HIGH_CYC - 1);
  wire lowTrip = lowCnt_reg >= TW'(AVG_LOW_CYC - 1);
  // counts hold at the trip point and clear when the comparator drops
  wire [TW-1:0] highCntNext = !sense.avgOvercurrentHigh ? '0
    : (highTrip ? highCnt_reg : highCnt_reg + 1'b1);
  wire [TW-1:0] lowCntNext = !sense.avgOvercurrentLow ? '0
    : (lowTrip ? lowCnt_reg : lowCnt_reg + 1'b1);
  // fourth consecutive positive half with a peak event
  wire peakTrip = botFall && peakSeen_reg && (peakRun_reg == 3'(`LPG_PEAK_COUNT - 1));
  // comparator already sits on the threshold picked by the held fault
  wire bulkOverNext = sense.bulkOverCmp;
  // held aux sample over its limit
  wire outTrip = sample_reg && sense.auxOverCmp;

  // next phase: a dead time always separates the two gates
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      // wait for permission, then open with a dead time
      LPG_IDLE: begin
        if (!stopNow) begin
          phase_next = LPG_DEAD_TO_TOP;
        end
      end
      // top gate conducting for the on time
      LPG_TOP_ON: begin
        if (stopNow) begin
          phase_next = LPG_IDLE;
        end else if (onEnd) begin
          phase_next = LPG_DEAD_TO_BOT;
        end
      end
      // dead time towards the bottom gate
      LPG_DEAD_TO_BOT: begin
        if (stopNow) begin
          phase_next = LPG_IDLE;
        end else if (deadEnd) begin
          phase_next = LPG_BOT_ON;
        end
      end
      // bottom gate conducting for the on time
      LPG_BOT_ON: begin
        if (stopNow) begin
          phase_next = LPG_IDLE;
        end else if (onEnd) begin
          phase_next = LPG_DEAD_TO_TOP;
        end
      end
      // dead time towards the top gate
      LPG_DEAD_TO_TOP: begin
        if (stopNow) begin
          phase_next = LPG_IDLE;
        end else if (deadEnd) begin
          phase_next = LPG_TOP_ON;
        end
      end
      // unused codes fall back to idle
      default: begin
        phase_next = LPG_IDLE;
      end
    endcase
  end

  // phase register and its timer
  always_ff @(posedge clock) begin
    if (!rstn) begin
      phase_reg <= LPG_IDLE;
      phaseCnt_reg <= '0;
      dirPrev_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      phaseCnt_reg <= (phase_next != phase_reg) ? '0 : phaseCnt_reg + 1'b1;
      dirPrev_reg <= sense.currentDirection;
    end
  end

  // bulk start and stop gating
  always_ff @(posedge clock) begin
    if (!rstn) running_reg <= 1'b0;
    else if (sense.bulkStop || sense.overTemp) running_reg <= 1'b0;
    else if (sense.bulkStart) running_reg <= 1'b1;
  end

  // gate outputs with undervoltage overrides
  always_ff @(posedge clock) begin
    if (!rstn) begin
      topGate_reg <= 1'b0;
      botGate_reg <= 1'b0;
    end else begin
      // top gate also drops on its own supply undervoltage
      topGate_reg <= (phase_next == LPG_TOP_ON) && topAllowed;
      botGate_reg <= (phase_next == LPG_BOT_ON) && !stopNow;
    end
  end

  // average overcurrent persistence timers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      highCnt_reg <= '0;
      lowCnt_reg <= '0;
    end else begin
      highCnt_reg <= highCntNext;
      lowCnt_reg <= lowCntNext;
    end
  end

  // peak overcurrent cycle counting
  always_ff @(posedge clock) begin
    if (!rstn || phase_reg == LPG_IDLE) begin
      startCnt_reg <= '0;
      peakRun_reg <= '0;
      peakSeen_reg <= 1'b0;
    end else begin
      if (phase_reg == LPG_TOP_ON && peakArmed && sense.peakOvercurrent)
        peakSeen_reg <= 1'b1;
      if (botFall) begin
        if (!peakArmed) startCnt_reg <= startCnt_reg + 1'b1;
        peakRun_reg <= peakSeen_reg ? peakRun_reg + 1'b1 : '0;
        peakSeen_reg <= 1'b0;
      end
    end
  end

  // capacitive region flag, refreshed at each gate falling edge
  always_ff @(posedge clock) begin
    if (!rstn) begin
      capFlag_reg <= 1'b0;
    end else begin
      // a clean half clears it, a bad one sets it
      capFlag_reg <= capFlagNext;
    end
  end

  // bulk hysteresis and aux winding sample
  always_ff @(posedge clock) begin
    if (!rstn) begin
      bulkOver_reg <= 1'b0;
      sample_reg <= 1'b0;
    end else begin
      bulkOver_reg <= bulkOverNext;
      sample_reg <= botFall;
    end
  end

  // sticky faults with set winning over clear, level faults follow their inputs
  always_ff @(posedge clock) begin
    if (!rstn) faults_reg <= '0;
    else begin
      faults_reg.peakOver <= peakTrip || (faults_reg.peakOver && !faultClear);
      faults_reg.avgHigh <= highTrip || (faults_reg.avgHigh && !faultClear);
      faults_reg.avgLow <= lowTrip || (faults_reg.avgLow && !faultClear);
      faults_reg.bulkOver <= bulkOver_reg;
      faults_reg.bulkUnder <= sense.bulkStop;
      faults_reg.outOver <= outTrip || (faults_reg.outOver && !faultClear);
      faults_reg.railUv <= sense.railUv;
      faults_reg.overTemp <= sense.overTemp;
    end
  end

  // registered auxiliary outputs
  always_ff @(posedge clock) begin
    if (!rstn) begin
      avgMuxPass <= 1'b0;
      auxSampleStrobe <= 1'b0;
      rampPullDown <= 1'b0;
      rampDone <= 1'b0;
      driverLowPower <= 1'b0;
      startSourceOff <= 1'b0;
      bulkOverSelFall <= 1'b0;
    end else begin
      // mux passes exactly while the top gate is driven
      avgMuxPass <= (phase_next == LPG_TOP_ON) && topAllowed;
      // strobe marks the bottom turn-off edge
      auxSampleStrobe <= botFall;
      // pull-down and ramp done track the flag in the same clock
      rampPullDown <= capFlagNext;
      rampDone <= rampEnable && !capFlagNext && !sense.fbBelowRamp;
      // driver and start source controls
      driverLowPower <= burstOff;
      startSourceOff <= sense.overTemp;
      // falling threshold chosen while the fault is held
      bulkOverSelFall <= bulkOver_reg;
    end
  end

  assign topGateDrive = topGate_reg;
  assign bottomGateDrive = botGate_reg;
  assign capacitiveFlag = capFlag_reg;
  assign faults = faults_reg;
endmodule

// [include/lpg_params.svh]
// constants and cycle conversions for the protection and gate sequencer
`ifndef LPG_PARAMS_SVH
`define LPG_PARAMS_SVH
`define LPG_CLK_HZ 10000000
`define LPG_BLANK_NS 400
`define LPG_BLANK_CYC ((`LPG_BLANK_NS * (`LPG_CLK_HZ / 1000000) + 999) / 1000)
`define LPG_AVG_HIGH_US 2000
`define LPG_AVG_HIGH_CYC (`LPG_AVG_HIGH_US * (`LPG_CLK_HZ / 1000000))
`define LPG_AVG_LOW_US 50000
`define LPG_AVG_LOW_CYC (`LPG_AVG_LOW_US * (`LPG_CLK_HZ / 1000000))
`define LPG_PEAK_COUNT 4
`define LPG_PEAK_IGNORE 15
`define LPG_MAX_DEAD_CYC 20
`define LPG_ONTIME_CYC 50
`endif

// [include/lpg_pkg.sv]
// types for the protection and gate sequencer
package lpg_pkg;
  typedef enum logic [2:0] {
    LPG_IDLE, LPG_TOP_ON, LPG_DEAD_TO_BOT, LPG_BOT_ON, LPG_DEAD_TO_TOP
  } lpg_phase_t;
  // fault indications, one bit each
  typedef struct packed {
    logic peakOver;
    logic avgHigh;
    logic avgLow;
    logic bulkOver;
    logic bulkUnder;
    logic outOver;
    logic railUv;
    logic overTemp;
  } lpg_faults_t;
  // comparator inputs
  typedef struct packed {
    logic currentDirection;
    logic peakOvercurrent;
    logic avgOvercurrentHigh;
    logic avgOvercurrentLow;
    logic bulkStart;
    logic bulkStop;
    logic bulkOverCmp;
    logic auxOverCmp;
    logic slewDone;
    logic bootUv;
    logic railUv;
    logic overTemp;
    logic fbBelowRamp;
  } lpg_sense_t;
endpackage

// [tb/lpg_sequencer_checker.sv]
// assertion checker for the protection and gate sequencer
`timescale 1ns/1ps
module lpg_sequencer_checker #(
  parameter int AVG_HIGH_CYC = 20
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // watched inputs
  input wire lpg_pkg::lpg_sense_t sense,
  input wire logic burstOff,
  // watched outputs
  input wire logic topGateDrive,
  input wire logic bottomGateDrive,
  input wire logic avgMuxPass,
  input wire logic rampPullDown,
  input wire logic driverLowPower,
  input wire logic startSourceOff,
  input wire logic bulkOverSelFall,
  input wire logic capacitiveFlag,
  input wire lpg_pkg::lpg_faults_t faults
);
  import lpg_pkg::*;
  int hiRun; // run of the high average comparator
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // counts unbroken high samples
  always_ff @(posedge clock) begin
    hiRun <= (!rstn || !sense.avgOvercurrentHigh) ? 0 : hiRun + 1;
  end
  property p_noOverlap; !(topGateDrive && bottomGateDrive); endproperty
  a_noOverlap: assert property (p_noOverlap) else $error("gates overlap");
  property p_mux; avgMuxPass == topGateDrive; endproperty
  a_mux: assert property (p_mux) else $error("mux select wrong");
  property p_avgHigh; $rose(faults.avgHigh) |-> hiRun >= AVG_HIGH_CYC; endproperty
  a_avgHigh: assert property (p_avgHigh) else $error("average fault early");
  property p_bootUv; sense.bootUv [*3] |-> !topGateDrive; endproperty
  a_bootUv: assert property (p_bootUv) else $error("top on in boot uv");
  property p_railUv; sense.railUv [*3] |-> !topGateDrive && !bottomGateDrive; endproperty
  a_railUv: assert property (p_railUv) else $error("gate on in rail uv");
  property p_lowPower; burstOff [*2] |-> driverLowPower; endproperty
  a_lowPower: assert property (p_lowPower) else $error("no low power");
  property p_hot; sense.overTemp [*3] |-> startSourceOff && !topGateDrive && !bottomGateDrive;
  endproperty
  a_hot: assert property (p_hot) else $error("hot but active");
  property p_pull; rampPullDown == capacitiveFlag; endproperty
  a_pull: assert property (p_pull) else $error("pull-down wrong");
  property p_sel; $stable(faults.bulkOver) |-> bulkOverSelFall == faults.bulkOver; endproperty
  a_sel: assert property (p_sel) else $error("threshold select wrong");
  property p_stop; (|faults) [*3] |-> !topGateDrive && !bottomGateDrive; endproperty
  a_stop: assert property (p_stop) else $error("gate on in fault");
  // main scenarios reached
  c_avg: cover property (faults.avgHigh);
  c_cap: cover property (capacitiveFlag);
  c_swap: cover property (topGateDrive ##1 !topGateDrive);
endmodule
bind lpg_sequencer lpg_sequencer_checker #(.AVG_HIGH_CYC(AVG_HIGH_CYC)) i_chk (.*);

// [tb/lpg_partner_model.sv]
// switch node and current direction model facing the gate outputs
`timescale 1ns/1ps
module lpg_partner_model (
  // clock and gates
  input wire logic clock,
  input wire logic topGateDrive,
  input wire logic bottomGateDrive,
  // modes set by the bench
  input wire logic slewEn,
  input wire logic capMode,
  // sensed node
  output logic slewDone,
  output logic currentDirection
);
  logic lastTop = 1'b0; // last switch that conducted
  logic [3:0] deadCnt = 4'h0; // cycles since both gates dropped
  // current follows the last switch, inverted when capacitive
  assign currentDirection = lastTop ^ capMode;
  // slew ends three cycles into dead time, if enabled
  assign slewDone = slewEn && deadCnt == 4'h3;
  // node tracking
  always @(posedge clock) begin
    if (topGateDrive || bottomGateDrive) lastTop <= topGateDrive;
    deadCnt <= (topGateDrive || bottomGateDrive) ? 4'h0 : deadCnt + {3'h0, deadCnt != 4'hf};
  end
endmodule

// [tb/lpg_sequencer_tb.sv]
// self-checking bench for the protection and gate sequencer
`timescale 1ns/1ps
module lpg_sequencer_tb;
  import lpg_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  lpg_sense_t sIn = '0; // bench comparators
  lpg_sense_t sense;
  logic rampEnable = 1'b0, burstOff = 1'b0, faultClear = 1'b0, slewEn = 1'b1, capMode = 1'b0;
  logic topGateDrive, bottomGateDrive, avgMuxPass, auxSampleStrobe, rampPullDown, rampDone;
  logic driverLowPower, startSourceOff, bulkOverSelFall, capacitiveFlag, slewDone;
  logic currentDirection;
  lpg_faults_t faults;
  int mismatches = 0, total_checks = 0, topRises = 0;
  lpg_sequencer #(.AVG_HIGH_CYC(20), .AVG_LOW_CYC(50)) i_dut (.*);
  lpg_partner_model i_far (.*);
  // merge partner lines into the comparators
  always_comb begin
    sense = sIn;
    sense.currentDirection = currentDirection;
    sense.slewDone = slewDone;
  end
  initial forever #50 clock = ~clock;
  always @(posedge topGateDrive) topRises++;
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n); repeat (n) @(negedge clock); endtask
  // reset, then request start if st is set
  task automatic go(int n, logic st);
    rstn = 1'b0;
    sIn = '0;
    {capMode, rampEnable, burstOff} = 3'h0;
    cyc(n);
    rstn = 1'b1;
    topRises = 0;
    sIn.bulkStart = st;
  endtask
  task automatic topFall();
    for (int k = 0; k < 300 && !topGateDrive; k++) @(negedge clock);
    for (int k = 0; k < 300 && topGateDrive; k++) @(negedge clock);
  endtask
  task automatic t_start();
    go(12, 1'b0);
    cyc(60);
    chk("idle top", 0, topGateDrive);
    for (int s = 0; s < 2; s++) begin
      slewEn = s[0];
      go(2, 1'b1);
      topFall();
      cyc(7);
      chk("early bottom", s[7:0], bottomGateDrive);
      cyc(20);
      chk("late bottom", 1, bottomGateDrive);
    end
    sIn.bulkStop = 1'b1;
    cyc(4);
    chk("stopped", 0, {topGateDrive, bottomGateDrive});
    $display("test start done");
  endtask
  task automatic t_avg();
    for (int i = 0; i < 2; i++) begin
      go(2, 1'b1);
      sIn[10-i] = 1'b1;
      cyc(i ? 45 : 17);
      sIn[10-i] = 1'b0;
      cyc(2);
      sIn[10-i] = 1'b1;
      cyc(i ? 45 : 17);
      chk("avg held short", 0, faults[6-i]);
      cyc(10);
      chk("avg held long", 1, faults[6-i]);
      cyc(3);
      chk("avg stop", 0, {topGateDrive, bottomGateDrive});
      sIn[10-i] = 1'b0;
      faultClear = 1'b1;
      cyc(2);
      chk("avg clear", 0, faults[6-i]);
      faultClear = 1'b0;
    end
    $display("test average done");
  endtask
  task automatic t_peak();
    go(2, 1'b1);
    sIn.peakOvercurrent = 1'b1;
    for (int k = 0; k < 3000 && topRises < 15; k++) @(negedge clock);
    chk("peak ignored", 0, faults.peakOver);
    for (int k = 0; k < 1000 && topRises < 20; k++) @(negedge clock);
    chk("peak fault", 1, faults.peakOver);
    $display("test peak done");
  endtask
  task automatic t_prot();
    go(2, 1'b1);
    sIn.auxOverCmp = 1'b1;
    cyc(250);
    chk("out over", 1, faults.outOver);
    go(2, 1'b1);
    {sIn.bulkOverCmp, sIn.bootUv, burstOff, sIn.overTemp} = 4'hf;
    cyc(5);
    chk("protect", 8'h0f, {faults.bulkOver, bulkOverSelFall,
      driverLowPower, startSourceOff});
    sIn.railUv = 1'b1;
    cyc(5);
    chk("uv gates", 0, {topGateDrive, bottomGateDrive});
    $display("test protect done");
  endtask
  task automatic t_cap();
    go(2, 1'b1);
    {rampEnable, capMode} = 2'h3;
    cyc(250);
    chk("cap set", 8'h06, {capacitiveFlag, rampPullDown, rampDone});
    capMode = 1'b0;
    cyc(250);
    chk("cap clear", 8'h01, {capacitiveFlag, rampPullDown, rampDone});
    $display("test capacitive done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog over the expected run length
  initial begin
    #3000000;
    mismatches++;
    results();
  end
  initial begin
    t_start();
    t_avg();
    t_peak();
    t_prot();
    t_cap();
    results();
  end
endmodule
